// file: image_load_pkg.sv
`default_nettype none
package image_load_pkg;

  // ****************************************************************
  // Access port geometry
  // ****************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W   = 4;
  localparam int unsigned DWA_W  = ADDR_W - 2;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] word_t;
  typedef logic [BE_W-1:0]   be_t;
  typedef logic [DWA_W-1:0]  dw_addr_t;

  localparam be_t BE_ALL = 4'hf;

  // ****************************************************************
  // Register byte offsets (configuration space)
  // ****************************************************************
  localparam addr_t OFF_PROG_CTRL   = 12'h22c;
  localparam addr_t OFF_STATUS      = 12'hb9e;
  localparam addr_t OFF_MODE_CTRL   = 12'hba0;
  localparam addr_t OFF_DATA_PORT   = 12'hba4;
  localparam addr_t OFF_DATA_ALIAS  = 12'hba8;
  localparam addr_t OFF_CREDIT      = 12'hbc8;

  // Status halfword sits in the upper half of its dword
  localparam int unsigned STATUS_SHIFT = 16;
  localparam int unsigned STATUS_W     = 16;

  // ****************************************************************
  // Status field positions
  // ****************************************************************
  localparam int unsigned ST_CORE_OK    = 10;
  localparam int unsigned ST_CLK_SEL    = 8;
  localparam int unsigned ST_DONE       = 7;
  localparam int unsigned ST_RUNNING    = 5;
  localparam int unsigned ST_LOAD_EN    = 4;
  localparam int unsigned ST_ERROR      = 3;
  localparam int unsigned ST_READY      = 2;

  // Index of each input in the synchronised status vector
  localparam int unsigned SI_CORE_OK = 0;
  localparam int unsigned SI_CLK_SEL = 1;
  localparam int unsigned SI_DONE    = 2;
  localparam int unsigned SI_RUNNING = 3;
  localparam int unsigned SI_LOAD_EN = 4;
  localparam int unsigned SI_ERROR   = 5;
  localparam int unsigned SI_READY   = 6;
  localparam int unsigned SI_CREDIT  = 7;
  localparam int unsigned SI_W       = 8;

  // ****************************************************************
  // Control field positions
  // ****************************************************************
  localparam int unsigned MC_LOAD_MODE = 0;
  localparam int unsigned MC_APP_OFF   = 1;
  localparam int unsigned PC_LOAD_REQ  = 0;
  localparam int unsigned PC_XFER      = 1;

  localparam int unsigned CREDIT_LSB   = 8;
  localparam int unsigned CREDIT_W     = 8;

  localparam word_t WORD_ZERO = 32'h0000_0000;

endpackage
`default_nettype wire

// file: level_sync.sv
`default_nettype none
module level_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // First stage feeds only the second stage
  always_comb begin
    state_next.meta   = async_in;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stable;

endmodule
`default_nettype wire

// file: credit_total.sv
`default_nettype none
module credit_total #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             free_toggle,
  output var  logic [WIDTH-1:0] total
);

  typedef struct packed {
    logic             last;
    logic [WIDTH-1:0] count;
  } credit_state_t;

  credit_state_t state_reg;
  credit_state_t state_next;

  // Each toggle means one more 4k buffer is free; count wraps freely
  always_comb begin
    state_next      = state_reg;
    state_next.last = free_toggle;
    if (free_toggle != state_reg.last) begin
      state_next.count = state_reg.count + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign total = state_reg.count;

endmodule
`default_nettype wire

// file: pcie_core_image_load_regs.sv
`default_nettype none
// Summary of operation
// - Status bit 10 shows the core image loaded successfully.
// - Status bit 7 shows protocol loading finished without error.
// - Status bit 5 is 1 while the fabric runs in user mode.
// - Status bit 4 shows the protocol load mode is enabled.
// - Status bit 3 mirrors the internal configuration error signal.
// - Status bit 2 resets to 0 then mirrors readiness for data.
// - Status bit 8 mirrors the fabric clock switch signal for debug.
// - Mode bit 1 set turns the application interface off; resets 0.
// - Mode bit 1 is writable only while load mode is enabled.
// - Reserved mode bit 2 always reads 0; host writes 0.
// - Each full-dword data word written goes to the config manager, except a BAR word in the same cycle as a config data word; resets 0.
// - Data port takes config writes, and BAR memory writes in load mode.
// - Program control bit 1 drives the transfer start output; resets 0.
// - Program control bit 0 requests an image transfer; resets 0.
// - Credit bits 15:8 hold low 8 bits of granted 4k credits.
// - Load enabled flag means the periphery image is already loaded.
module pcie_core_image_load_regs
  import image_load_pkg::*;
#(
  parameter int unsigned CREDIT_BITS = image_load_pkg::CREDIT_W
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  // Configuration space access
  input  wire logic                        cfg_wr,
  input  wire logic                        cfg_rd,
  input  wire image_load_pkg::addr_t       cfg_addr,
  input  wire image_load_pkg::word_t       cfg_wdata,
  input  wire image_load_pkg::be_t         cfg_be,
  output var  image_load_pkg::word_t       cfg_rdata,
  output var  logic                        cfg_rd_valid,
  // Memory-space BAR writes, any address
  input  wire logic                        mem_wr,
  input  wire image_load_pkg::word_t       mem_wdata,
  input  wire image_load_pkg::be_t         mem_be,
  // Device status, from outside this clock domain
  input  wire logic                        core_load_ok_flag,
  input  wire logic                        fabric_clock_selected,
  input  wire logic                        load_complete_flag,
  input  wire logic                        fabric_running_flag,
  input  wire logic                        periph_image_loaded,
  input  wire logic                        load_error_flag,
  input  wire logic                        load_ready_flag,
  input  wire logic                        buffer_free_toggle,
  // Towards the configuration manager and fabric interface
  output var  logic                        app_interface_off,
  output var  logic                        transfer_begin,
  output var  logic                        load_request,
  output var  logic                        protocol_load_mode,
  output var  image_load_pkg::word_t       config_manager_data,
  output var  logic                        config_manager_valid
);
  import image_load_pkg::*;

  // ****************************************************************
  // Status inputs
  // ****************************************************************
  logic [SI_W-1:0]        raw_status;
  logic [SI_W-1:0]        sync_status;
  logic [CREDIT_BITS-1:0] credit_count;

  assign raw_status[SI_CORE_OK] = core_load_ok_flag;
  assign raw_status[SI_CLK_SEL] = fabric_clock_selected;
  assign raw_status[SI_DONE]    = load_complete_flag;
  assign raw_status[SI_RUNNING] = fabric_running_flag;
  assign raw_status[SI_LOAD_EN] = periph_image_loaded;
  assign raw_status[SI_ERROR]   = load_error_flag;
  assign raw_status[SI_READY]   = load_ready_flag;
  assign raw_status[SI_CREDIT]  = buffer_free_toggle;

  level_sync #(
    .WIDTH (SI_W)
  ) u_status_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (raw_status),
    .sync_out (sync_status)
  );

  credit_total #(
    .WIDTH (CREDIT_BITS)
  ) u_credit (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .free_toggle (sync_status[SI_CREDIT]),
    .total       (credit_count)
  );

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic dw_hit(input addr_t a, input addr_t off);
    dw_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction

  function automatic logic is_data_port(input addr_t a);
    is_data_port = dw_hit(a, OFF_DATA_PORT) || dw_hit(a, OFF_DATA_ALIAS);
  endfunction

  // ****************************************************************
  // Register state
  // ****************************************************************
  typedef struct packed {
    logic  app_off;
    logic  load_mode;
    logic  xfer;
    logic  req;
    word_t data;
    logic  data_valid;
    word_t rdata;
    logic  rd_valid;
  } regs_state_t;

  regs_state_t state_reg;
  regs_state_t state_next;

  logic [STATUS_W-1:0] status_word;
  word_t               read_word;
  logic                load_en;
  logic                cfg_data_wr;
  logic                mem_data_wr;

  assign load_en = sync_status[SI_LOAD_EN];

  always_comb begin
    status_word              = '0;
    status_word[ST_CORE_OK]  = sync_status[SI_CORE_OK];
    status_word[ST_CLK_SEL]  = sync_status[SI_CLK_SEL];
    status_word[ST_DONE]     = sync_status[SI_DONE];
    status_word[ST_RUNNING]  = sync_status[SI_RUNNING];
    status_word[ST_LOAD_EN]  = load_en;
    status_word[ST_ERROR]    = sync_status[SI_ERROR];
    status_word[ST_READY]    = sync_status[SI_READY];
  end

  // Unmapped dwords and reserved bits read as zero
  always_comb begin
    read_word = WORD_ZERO;
    if (dw_hit(cfg_addr, OFF_STATUS)) begin
      read_word[STATUS_SHIFT +: STATUS_W] = status_word;
    end else if (dw_hit(cfg_addr, OFF_MODE_CTRL)) begin
      read_word[MC_LOAD_MODE] = state_reg.load_mode;
      read_word[MC_APP_OFF]   = state_reg.app_off;
    end else if (is_data_port(cfg_addr)) begin
      read_word = state_reg.data;
    end else if (dw_hit(cfg_addr, OFF_PROG_CTRL)) begin
      read_word[PC_LOAD_REQ] = state_reg.req;
      read_word[PC_XFER]     = state_reg.xfer;
    end else if (dw_hit(cfg_addr, OFF_CREDIT)) begin
      read_word[CREDIT_LSB +: CREDIT_BITS] = credit_count;
    end
  end

  // Partial-dword data writes are dropped rather than sent half-formed
  assign cfg_data_wr = cfg_wr && is_data_port(cfg_addr) && (cfg_be == BE_ALL);
  assign mem_data_wr = mem_wr && state_reg.load_mode && (mem_be == BE_ALL);

  always_comb begin
    state_next            = state_reg;
    state_next.data_valid = 1'b0;
    state_next.rd_valid   = cfg_rd;
    if (cfg_rd) begin
      state_next.rdata = read_word;
    end
    if (cfg_wr && dw_hit(cfg_addr, OFF_MODE_CTRL) && cfg_be[0]) begin
      state_next.load_mode = cfg_wdata[MC_LOAD_MODE];
      // Read-only unless protocol loading is enabled
      if (load_en) begin
        state_next.app_off = cfg_wdata[MC_APP_OFF];
      end
    end
    if (cfg_wr && dw_hit(cfg_addr, OFF_PROG_CTRL) && cfg_be[0]) begin
      state_next.req  = cfg_wdata[PC_LOAD_REQ];
      state_next.xfer = cfg_wdata[PC_XFER];
    end
    // Config write wins if both arrive in one cycle; host never does this
    if (cfg_data_wr) begin
      state_next.data       = cfg_wdata;
      state_next.data_valid = 1'b1;
    end else if (mem_data_wr) begin
      state_next.data       = mem_wdata;
      state_next.data_valid = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign cfg_rdata            = state_reg.rdata;
  assign cfg_rd_valid         = state_reg.rd_valid;
  assign app_interface_off    = state_reg.app_off;
  assign transfer_begin       = state_reg.xfer;
  assign load_request         = state_reg.req;
  assign protocol_load_mode   = state_reg.load_mode;
  assign config_manager_data  = state_reg.data;
  assign config_manager_valid = state_reg.data_valid;

endmodule
`default_nettype wire

// file: image_load_chk.sv
`default_nettype none
module image_load_chk
  import image_load_pkg::*;
#(
  parameter int unsigned CREDIT_BITS = 8
) (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire logic                  cfg_wr,
  input wire logic                  cfg_rd,
  input wire image_load_pkg::addr_t cfg_addr,
  input wire image_load_pkg::word_t cfg_wdata,
  input wire image_load_pkg::be_t   cfg_be,
  input wire image_load_pkg::word_t cfg_rdata,
  input wire logic                  cfg_rd_valid,
  input wire logic                  mem_wr,
  input wire image_load_pkg::word_t mem_wdata,
  input wire image_load_pkg::be_t   mem_be,
  input wire logic                  app_interface_off,
  input wire logic                  transfer_begin,
  input wire logic                  load_request,
  input wire logic                  protocol_load_mode,
  input wire image_load_pkg::word_t config_manager_data,
  input wire logic                  config_manager_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ****************************************************************
  // Access port and data stream
  // ****************************************************************
  AST_RD_VALID: assert property (cfg_rd |=> cfg_rd_valid)
    else $error("read answer missing");
  AST_RD_QUIET: assert property (!cfg_rd |=> !cfg_rd_valid)
    else $error("read answer without request");
  AST_CFG_DATA: assert property (cfg_wr && cfg_addr == OFF_DATA_PORT && cfg_be == BE_ALL
    |=> config_manager_valid && config_manager_data == $past(cfg_wdata))
    else $error("config data word not forwarded");
  AST_MEM_DATA: assert property (mem_wr && !cfg_wr && protocol_load_mode && mem_be == BE_ALL
    |=> config_manager_valid && config_manager_data == $past(mem_wdata))
    else $error("memory data word not forwarded");
  AST_MEM_GATE: assert property (mem_wr && !cfg_wr && !protocol_load_mode
    |=> !config_manager_valid)
    else $error("memory write forwarded outside load mode");
  AST_PARTIAL: assert property (!mem_wr && cfg_be != BE_ALL |=> !config_manager_valid)
    else $error("partial data word forwarded");
  AST_IDLE: assert property (!cfg_wr && !mem_wr |=> !config_manager_valid)
    else $error("data valid without a write");
  // ****************************************************************
  // Control registers
  // ****************************************************************
  AST_PROG: assert property (cfg_wr && cfg_addr[11:2] == OFF_PROG_CTRL[11:2] && cfg_be[0]
    |=> {transfer_begin, load_request} == $past(cfg_wdata[1:0]))
    else $error("program control outputs wrong after write");
  AST_HOLD: assert property (!cfg_wr |=> $stable(load_request) && $stable(transfer_begin)
    && $stable(app_interface_off))
    else $error("control output moved without a write");
  AST_MODE_RSVD: assert property (cfg_rd && cfg_addr[11:2] == OFF_MODE_CTRL[11:2]
    |=> cfg_rdata[31:2] == 30'h0)
    else $error("mode control reserved bits not zero");
  AST_CREDIT_RSVD: assert property (cfg_rd && cfg_addr[11:2] == OFF_CREDIT[11:2]
    |=> cfg_rdata[31:16] == 16'h0 && cfg_rdata[7:0] == 8'h0)
    else $error("credit reserved bits not zero");
  COV_MEM: cover property (mem_wr && protocol_load_mode ##1 config_manager_valid);
  COV_APP: cover property ($rose(app_interface_off));
  COV_RD: cover property (cfg_rd ##1 cfg_rd_valid);
endmodule
`default_nettype wire

// file: cfg_mgr_model.sv
`default_nettype none
module cfg_mgr_model #(
  parameter int unsigned WORDS = 8
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic load_request,
  input  wire logic config_manager_valid,
  output var  logic load_ready_flag,
  output var  logic buffer_free_toggle,
  output var  logic load_complete_flag,
  output var  logic fabric_running_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned words;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      words <= 0;
      load_ready_flag <= 1'b0;
      buffer_free_toggle <= 1'b0;
    end else begin
      load_ready_flag <= load_request;
      if (config_manager_valid === 1'b1) begin
        words <= words + 1;
        // One more 4k buffer frees after every fourth word
        if ((words + 1) % 4 == 0) buffer_free_toggle <= ~buffer_free_toggle;
      end
    end
  end
  assign load_complete_flag = (words >= WORDS);
  assign fabric_running_flag = load_complete_flag && !load_request;
endmodule
`default_nettype wire

// file: tb_pcie_core_image_load_regs.sv
`default_nettype none
module tb_pcie_core_image_load_regs;
  import image_load_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CREDIT_BITS = 8;
  // 10 us of link silence at 10 ns per cycle
  localparam int unsigned QUIET_CYC   = 1000;
  logic  sys_clk = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, mem_wr = 0;
  logic  periph_image_loaded = 0, load_error_flag = 0, fabric_clock_selected = 0;
  logic  core_load_ok_flag = 0, cfg_rd_valid, app_interface_off, transfer_begin;
  logic  load_request, protocol_load_mode, config_manager_valid, load_ready_flag;
  logic  buffer_free_toggle, load_complete_flag, fabric_running_flag;
  addr_t cfg_addr = '0;
  word_t cfg_wdata = '0, mem_wdata = '0, cfg_rdata, config_manager_data, rv, last;
  be_t   cfg_be = BE_ALL, mem_be = BE_ALL;
  int    error_cnt = 0, n_checks = 0, nwords = 0, sent = 0, seq = 0, cyc = 0;
  addr_t regs[6] = '{OFF_PROG_CTRL, 12'hb9c, OFF_MODE_CTRL, OFF_DATA_PORT, OFF_CREDIT, 12'h100};

  pcie_core_image_load_regs #(.CREDIT_BITS(CREDIT_BITS)) pcie_core_image_load_regs_inst (
    .sys_clk(sys_clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_be(mem_be),
    .core_load_ok_flag(core_load_ok_flag), .fabric_clock_selected(fabric_clock_selected),
    .load_complete_flag(load_complete_flag), .fabric_running_flag(fabric_running_flag),
    .periph_image_loaded(periph_image_loaded), .load_error_flag(load_error_flag),
    .load_ready_flag(load_ready_flag), .buffer_free_toggle(buffer_free_toggle),
    .app_interface_off(app_interface_off), .transfer_begin(transfer_begin),
    .load_request(load_request), .protocol_load_mode(protocol_load_mode),
    .config_manager_data(config_manager_data), .config_manager_valid(config_manager_valid));
  cfg_mgr_model #(.WORDS(8)) cfg_mgr_model_inst (
    .sys_clk(sys_clk), .rst(rst), .load_request(load_request),
    .config_manager_valid(config_manager_valid), .load_ready_flag(load_ready_flag),
    .buffer_free_toggle(buffer_free_toggle), .load_complete_flag(load_complete_flag),
    .fabric_running_flag(fabric_running_flag));

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (config_manager_valid === 1'b1) nwords++;
  // Four quiet spans plus under a hundred cycles of traffic
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      results();
    end
  end

  // ****************************************************************
  // Access tasks; each starts and ends just after a falling edge
  // ****************************************************************
  task automatic chk(input string what, input word_t exp, input word_t got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input addr_t a, input word_t d);
    cfg_wr = 1;
    cfg_addr = a;
    cfg_wdata = d;
    cfg_be = BE_ALL;
    @(negedge sys_clk);
    cfg_wr = 0;
    @(negedge sys_clk);
  endtask
  task automatic rd(input addr_t a);
    cfg_rd = 1;
    cfg_addr = a;
    @(negedge sys_clk);
    cfg_rd = 0;
    chk("rd_valid", 1, cfg_rd_valid);
    rv = cfg_rdata;
    @(negedge sys_clk);
  endtask
  // Back-to-back data words; take says whether the device should keep them
  task automatic stream(input bit mem, input int n, input be_t b, input bit take);
    word_t w;
    for (int i = 0; i < n; i++) begin
      w = 32'hc0de_0000 + 32'(seq++);
      if (mem) begin
        mem_wr = 1;
        mem_wdata = w;
        mem_be = b;
      end else begin
        cfg_wr = 1;
        cfg_addr = OFF_DATA_PORT;
        cfg_wdata = w;
        cfg_be = b;
      end
      if (take) begin
        sent++;
        last = w;
      end
      @(negedge sys_clk);
    end
    cfg_wr = 0;
    mem_wr = 0;
    repeat (2) @(negedge sys_clk);
  endtask
  // No requests at all while the application interface switches
  task automatic link_quiet();
    repeat (QUIET_CYC) @(negedge sys_clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (3) @(negedge sys_clk);
    rst = 0;
    @(negedge sys_clk);
    wr(12'h100, 32'hffff_ffff);
    foreach (regs[i]) begin
      rd(regs[i]);
      chk("reset value", 0, rv);
    end
    $display("test reset values done");
    wr(OFF_MODE_CTRL, 32'h7);
    rd(OFF_MODE_CTRL);
    chk("mode locked", 32'h1, rv);
    chk("app off locked", 0, app_interface_off);
    periph_image_loaded = 1;
    repeat (4) @(negedge sys_clk);
    link_quiet();
    wr(OFF_MODE_CTRL, 32'h6);
    link_quiet();
    rd(OFF_MODE_CTRL);
    chk("mode app only", 32'h2, rv);
    chk("app off set", 1, app_interface_off);
    wr(OFF_MODE_CTRL, 32'h7);
    chk("load mode", 1, protocol_load_mode);
    $display("test mode control done");
    wr(OFF_PROG_CTRL, 32'h2);
    chk("transfer only", 32'h2, {30'h0, transfer_begin, load_request});
    wr(OFF_PROG_CTRL, 32'h3);
    chk("load request", 1, load_request);
    chk("transfer begin", 1, transfer_begin);
    repeat (4) @(negedge sys_clk);
    rd(12'hb9c);
    chk("status ready", 32'h0000_0014, (rv >> STATUS_SHIFT) & 32'h05bc);
    stream(0, 4, BE_ALL, 1);
    stream(1, 4, BE_ALL, 1);
    stream(0, 1, 4'h7, 0);
    stream(1, 1, 4'he, 0);
    chk("word count", 32'(sent), 32'(nwords));
    chk("last word", last, config_manager_data);
    rd(OFF_DATA_PORT);
    chk("data readback", last, rv);
    wr(OFF_DATA_ALIAS, 32'h5a5a_0001);
    sent++;
    last = 32'h5a5a_0001;
    chk("alias word", last, config_manager_data);
    repeat (6) @(negedge sys_clk);
    rd(OFF_CREDIT);
    chk("credits", 32'(sent / 4) << CREDIT_LSB, rv);
    $display("test image stream done");
    wr(OFF_PROG_CTRL, 32'h0);
    wr(OFF_MODE_CTRL, 32'h2);
    stream(1, 1, BE_ALL, 0);
    chk("mode off count", 32'(sent), 32'(nwords));
    load_error_flag = 1;
    fabric_clock_selected = 1;
    core_load_ok_flag = 1;
    repeat (4) @(negedge sys_clk);
    rd(12'hb9c);
    chk("status final", 32'h0000_05b8, (rv >> STATUS_SHIFT) & 32'h05bc);
    link_quiet();
    wr(OFF_MODE_CTRL, 32'h0);
    chk("app on", 0, app_interface_off);
    link_quiet();
    $display("test load exit done");
    results();
  end
endmodule

bind pcie_core_image_load_regs image_load_chk #(.CREDIT_BITS(CREDIT_BITS)) image_load_chk_inst (.*);
`default_nettype wire
